// >>> rtl/scfg_map.svh
// register offsets, field positions and reset values of the configuration bank
`ifndef SCFG_MAP_SVH
`define SCFG_MAP_SVH

`define SCFG_IDX_RATE_TABLE 8'h0B
`define SCFG_IDX_SERIAL_MODE 8'h0C
`define SCFG_IDX_DEVICE_ID 8'h0D
`define SCFG_IDX_REVISION 8'h0E
`define SCFG_IDX_TEST_BITS 8'h0F
`define SCFG_IDX_CLOCK_CTRL 8'h10
`define SCFG_IDX_IR_TEST 8'h11
`define SCFG_IDX_RSVD_FIRST 8'h12
`define SCFG_IDX_RSVD_LAST 8'h1D
`define SCFG_IDX_GAME_BASE 8'h1E
`define SCFG_IDX_DRIVE_TYPE 8'h1F

`define SCFG_RST_RATE_TABLE 8'h00
`define SCFG_RST_SERIAL_MODE 8'h00
`define SCFG_RST_TEST_BITS 8'h00
`define SCFG_RST_CLOCK_CTRL 8'h00
`define SCFG_RST_IR_TEST 8'h00
`define SCFG_RST_GAME_BASE 8'h80
`define SCFG_RST_DRIVE_TYPE 8'h00
`define SCFG_RST_INDEX 8'h00

`define SCFG_SM_RX_INV 0
`define SCFG_SM_TX_INV 1
`define SCFG_SM_HALF_DUPLEX 2
`define SCFG_SM_MODE_LSB 3
`define SCFG_SM_MODE_MSB 5
`define SCFG_SM_UART1_FAST 6
`define SCFG_SM_UART_FAST 7

`define SCFG_CK_PLL_GAIN 3
`define SCFG_CK_PLL_STOP 4
`define SCFG_CK_DIV_HALT 5
`define SCFG_CK_PLL_SRC 6
`define SCFG_CK_IR_TEST 7
`define SCFG_CK_WR_MASK 8'hF8

`define SCFG_IR_LOOPBACK 0
`define SCFG_IR_PD_TEST 1
`define SCFG_IR_WR_MASK 8'h03

`define SCFG_GB_DECODE_LSB 0
`define SCFG_GB_DECODE_MSB 1
`define SCFG_GB_ADDR_LSB 2
`define SCFG_GB_ADDR_MSB 7

`endif

// >>> rtl/scfg_pkg.sv
// types shared by the configuration bank
package scfg_pkg;

    typedef enum logic [2:0] {
        SCFG_SER_STANDARD = 3'h0,
        SCFG_SER_PULSE_IR = 3'h1,
        SCFG_SER_ASK_IR = 3'h2
    } scfg_serial_mode_t;

    typedef enum logic [1:0] {
        SCFG_GAME_OFF = 2'h0,
        SCFG_GAME_ONE_BYTE = 2'h1,
        SCFG_GAME_EIGHT_BYTE = 2'h2,
        SCFG_GAME_SIXTEEN_BYTE = 2'h3
    } scfg_game_decode_t;

    typedef enum logic [1:0] {
        SCFG_KIND_DENSITY = 2'h0,
        SCFG_KIND_RATE_HI_LO = 2'h1,
        SCFG_KIND_DENSITY_INV = 2'h2,
        SCFG_KIND_RATE_LO_HI = 2'h3
    } scfg_drive_kind_t;

endpackage

// >>> rtl/scfg_joystick_chip_select.sv
// joystick chip-select address decoder
`timescale 1ns/100ps
`default_nettype none
`include "scfg_map.svh"

module scfg_joystick_chip_select
    import scfg_pkg::*;
(
    // programmed base and decode mode
    input wire logic [7:0] game_base,
    input wire logic game_pin_enable,
    // qualified host address
    input wire logic [10:0] host_addr,
    input wire logic host_select_n,
    // decode result, active high
    output logic game_hit
);

    scfg_game_decode_t decode;
    logic upper_ok;
    logic low_ok;

    assign decode = scfg_game_decode_t'(game_base[`SCFG_GB_DECODE_MSB:`SCFG_GB_DECODE_LSB]);

    // base bits 7:2 carry address bits 9:4; A10 and host select must qualify
    assign upper_ok = !host_select_n && !host_addr[10] &&
        (host_addr[9:4] == game_base[`SCFG_GB_ADDR_MSB:`SCFG_GB_ADDR_LSB]);

    always_comb begin
        unique case (decode)
            SCFG_GAME_OFF: low_ok = 1'b0;
            SCFG_GAME_ONE_BYTE: low_ok = (host_addr[3:0] == 4'h1);
            SCFG_GAME_EIGHT_BYTE: low_ok = !host_addr[3];
            SCFG_GAME_SIXTEEN_BYTE: low_ok = 1'b1;
        endcase
    end

    // pin function select outranks the decode setting
    assign game_hit = game_pin_enable && upper_ok && low_ok;

endmodule
`default_nettype wire

// >>> rtl/scfg_regs.sv
// configuration register bank for indices 0B through 1F
`timescale 1ns/100ps
`default_nettype none
`include "scfg_map.svh"

module scfg_regs
    import scfg_pkg::*;
#(
    parameter logic [7:0] DEVICE_ID = 8'hA5, // arbitrary value
    parameter logic [7:0] REVISION = 8'h5A, // arbitrary value
    parameter int DRIVES = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // configuration access port
    input wire logic cfg_mode,
    input wire logic index_wr,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    output logic cfg_rvalid,
    output logic [7:0] config_index_reg,
    // floppy controller side
    input wire logic [1:0] fdc_drive_sel,
    input wire logic fdc_density_sel,
    input wire logic rate_bit0,
    input wire logic rate_bit1,
    output logic [1:0] rate_table_sel,
    output logic drive_density_out0,
    output logic drive_density_out1,
    output logic fdc_pd_timeout_test,
    // serial channels
    input wire logic uart1_tx_data,
    input wire logic uart2_tx_data,
    input wire logic uart2_tx_active,
    output logic uart2_rx_data,
    output logic serial_out_pin,
    output logic uart2_half_duplex,
    output logic [2:0] uart2_mode,
    output logic uart1_high_speed,
    output logic uart_high_speed,
    // infrared pins
    input wire logic ir_receive_pin,
    output logic ir_transmit_pin,
    // clock generator controls
    output logic pll_gain_double,
    output logic pll_stop,
    output logic serial_divider_halt,
    output logic pll_input_24m,
    output logic ir_test_mode,
    // game port decode
    input wire logic game_pin_enable,
    input wire logic host_select_n,
    input wire logic [10:0] host_addr,
    output logic joystick_chip_select_n
);

    // stored registers, synchronisers and internal decode signals
    logic [7:0] drive_rate_table_select;
    logic [7:0] serial_mode_control;
    logic [7:0] factory_test_bits;
    logic [7:0] clock_generator_control;
    logic [7:0] infrared_test_control;
    logic [7:0] game_select_base;
    logic [7:0] drive_type_select;
    logic wr_en;
    logic rd_en;
    logic [7:0] next_rdata;
    logic host_sel_meta_n;
    logic host_sel_sync_n;
    logic [10:0] addr_meta;
    logic [10:0] addr_sync;
    logic ir_rx_meta;
    logic ir_rx_sync;
    logic [1:0] rate_field [DRIVES];
    scfg_drive_kind_t kind_field [DRIVES];
    logic drive_kind_first [DRIVES];
    logic drive_kind_second [DRIVES];
    scfg_drive_kind_t cur_kind;
    logic density_select_inv;
    logic next_den0;
    logic next_den1;
    logic rx_source;
    logic next_rx;
    logic game_hit;

    assign wr_en = cfg_mode && data_wr;
    assign rd_en = cfg_mode && data_rd;

    // index register, only loaded while in configuration mode
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            config_index_reg <= `SCFG_RST_INDEX;
        end else if (cfg_mode && index_wr) begin
            config_index_reg <= cfg_wdata;
        end
    end

    // drive rate table select
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            drive_rate_table_select <= `SCFG_RST_RATE_TABLE;
        end else if (wr_en && config_index_reg == `SCFG_IDX_RATE_TABLE) begin
            drive_rate_table_select <= cfg_wdata;
        end
    end

    // serial mode control, cleared by any reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            serial_mode_control <= `SCFG_RST_SERIAL_MODE;
        end else if (wr_en && config_index_reg == `SCFG_IDX_SERIAL_MODE) begin
            serial_mode_control <= cfg_wdata;
        end
    end

    // test bits are stored as written; they steer nothing here
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            factory_test_bits <= `SCFG_RST_TEST_BITS;
        end else if (wr_en && config_index_reg == `SCFG_IDX_TEST_BITS) begin
            factory_test_bits <= cfg_wdata;
        end
    end

    // clock control, low three bits never store
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clock_generator_control <= `SCFG_RST_CLOCK_CTRL;
        end else if (wr_en && config_index_reg == `SCFG_IDX_CLOCK_CTRL) begin
            clock_generator_control <= cfg_wdata & `SCFG_CK_WR_MASK;
        end
    end

    // infrared test, only the two low bits store
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            infrared_test_control <= `SCFG_RST_IR_TEST;
        end else if (wr_en && config_index_reg == `SCFG_IDX_IR_TEST) begin
            infrared_test_control <= cfg_wdata & `SCFG_IR_WR_MASK;
        end
    end

    // game chip-select base and decode mode
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            game_select_base <= `SCFG_RST_GAME_BASE;
        end else if (wr_en && config_index_reg == `SCFG_IDX_GAME_BASE) begin
            game_select_base <= cfg_wdata;
        end
    end

    // drive type select
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            drive_type_select <= `SCFG_RST_DRIVE_TYPE;
        end else if (wr_en && config_index_reg == `SCFG_IDX_DRIVE_TYPE) begin
            drive_type_select <= cfg_wdata;
        end
    end

    // read mux; identifier, revision and reserved indices have no storage
    always_comb begin
        case (config_index_reg)
            `SCFG_IDX_RATE_TABLE: next_rdata = drive_rate_table_select;
            `SCFG_IDX_SERIAL_MODE: next_rdata = serial_mode_control;
            `SCFG_IDX_DEVICE_ID: next_rdata = DEVICE_ID;
            `SCFG_IDX_REVISION: next_rdata = REVISION;
            `SCFG_IDX_TEST_BITS: next_rdata = factory_test_bits;
            `SCFG_IDX_CLOCK_CTRL: next_rdata = clock_generator_control;
            `SCFG_IDX_IR_TEST: next_rdata = infrared_test_control;
            `SCFG_IDX_GAME_BASE: next_rdata = game_select_base;
            `SCFG_IDX_DRIVE_TYPE: next_rdata = drive_type_select;
            default: next_rdata = 8'h00;
        endcase
    end

    // read data held until the next read
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_rdata <= 8'h00;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= rd_en;
            if (rd_en) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

    // serial mode fields
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            uart2_half_duplex <= 1'b0;
            uart2_mode <= SCFG_SER_STANDARD;
            uart1_high_speed <= 1'b0;
            uart_high_speed <= 1'b0;
        end else begin
            uart2_half_duplex <= serial_mode_control[`SCFG_SM_HALF_DUPLEX];
            // reserved codes pass through unchanged; the channel decides
            uart2_mode <= serial_mode_control[`SCFG_SM_MODE_MSB:`SCFG_SM_MODE_LSB];
            uart1_high_speed <= serial_mode_control[`SCFG_SM_UART1_FAST];
            uart_high_speed <= serial_mode_control[`SCFG_SM_UART_FAST];
        end
    end

    // clock generator and test controls
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pll_gain_double <= 1'b0;
            pll_stop <= 1'b0;
            serial_divider_halt <= 1'b0;
            pll_input_24m <= 1'b0;
            ir_test_mode <= 1'b0;
            fdc_pd_timeout_test <= 1'b0;
        end else begin
            pll_gain_double <= clock_generator_control[`SCFG_CK_PLL_GAIN];
            pll_stop <= clock_generator_control[`SCFG_CK_PLL_STOP];
            // one level both gates the divider clock and holds it in reset
            serial_divider_halt <= clock_generator_control[`SCFG_CK_DIV_HALT];
            pll_input_24m <= clock_generator_control[`SCFG_CK_PLL_SRC];
            ir_test_mode <= clock_generator_control[`SCFG_CK_IR_TEST];
            fdc_pd_timeout_test <= infrared_test_control[`SCFG_IR_PD_TEST];
        end
    end

    // two-stage synchronisers for pins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            host_sel_meta_n <= 1'b1;
            host_sel_sync_n <= 1'b1;
            addr_meta <= 11'h000;
            addr_sync <= 11'h000;
            ir_rx_meta <= 1'b1;
            ir_rx_sync <= 1'b1;
        end else begin
            host_sel_meta_n <= host_select_n;
            host_sel_sync_n <= host_sel_meta_n;
            addr_meta <= host_addr;
            addr_sync <= addr_meta;
            ir_rx_meta <= ir_receive_pin;
            ir_rx_sync <= ir_rx_meta;
        end
    end

    // infrared transmit with optional inversion
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ir_transmit_pin <= 1'b1;
        end else begin
            ir_transmit_pin <= uart2_tx_data ^ serial_mode_control[`SCFG_SM_TX_INV];
        end
    end

    // loopback takes the transmit pin as it leaves the chip
    assign rx_source = infrared_test_control[`SCFG_IR_LOOPBACK] ? ir_transmit_pin : ir_rx_sync;

    // half duplex blanks receive to idle while transmitting, hiding own echo
    always_comb begin
        next_rx = rx_source ^ serial_mode_control[`SCFG_SM_RX_INV];
        if (serial_mode_control[`SCFG_SM_HALF_DUPLEX] && uart2_tx_active) begin
            next_rx = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            uart2_rx_data <= 1'b1;
        end else begin
            uart2_rx_data <= next_rx;
        end
    end

    // test mode merges receive and transmit; idle high so a low on either shows
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            serial_out_pin <= 1'b1;
        end else if (clock_generator_control[`SCFG_CK_IR_TEST]) begin
            serial_out_pin <= uart2_rx_data & ir_transmit_pin;
        end else begin
            serial_out_pin <= uart1_tx_data;
        end
    end

    // split per drive fields; the second type bit sits in the even position
    generate
        for (genvar d = 0; d < DRIVES; d++) begin : g_drive
            assign rate_field[d] = drive_rate_table_select[2 * d + 1 : 2 * d];
            assign drive_kind_second[d] = drive_type_select[2 * d];
            assign drive_kind_first[d] = drive_type_select[2 * d + 1];
            assign kind_field[d] = scfg_drive_kind_t'({drive_kind_first[d], drive_kind_second[d]});
        end
    endgenerate

    assign cur_kind = kind_field[fdc_drive_sel];
    assign density_select_inv = !fdc_density_sel;

    // density pin mapping for the selected drive
    always_comb begin
        unique case (cur_kind)
            SCFG_KIND_DENSITY: {next_den0, next_den1} = {fdc_density_sel, rate_bit0};
            SCFG_KIND_RATE_HI_LO: {next_den0, next_den1} = {rate_bit1, rate_bit0};
            SCFG_KIND_DENSITY_INV: {next_den0, next_den1} = {density_select_inv, rate_bit0};
            SCFG_KIND_RATE_LO_HI: {next_den0, next_den1} = {rate_bit0, rate_bit1};
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            drive_density_out0 <= 1'b0;
            drive_density_out1 <= 1'b0;
            rate_table_sel <= 2'h0;
        end else begin
            drive_density_out0 <= next_den0;
            drive_density_out1 <= next_den1;
            rate_table_sel <= rate_field[fdc_drive_sel];
        end
    end

    // game port address decode on synchronised host pins
    scfg_joystick_chip_select u_joystick_chip_select (
        .game_base(game_select_base),
        .game_pin_enable(game_pin_enable),
        .host_addr(addr_sync),
        .host_select_n(host_sel_sync_n),
        .game_hit(game_hit)
    );

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            joystick_chip_select_n <= 1'b1;
        end else begin
            joystick_chip_select_n <= !game_hit;
        end
    end

endmodule
`default_nettype wire

// >>> tb/scfg_regs_assertions.sv
// port checker for the configuration bank
`timescale 1ns/100ps
`default_nettype none
`include "scfg_map.svh"
module scfg_regs_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // access port
    input wire logic cfg_mode,
    input wire logic index_wr,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_rvalid,
    input wire logic [7:0] config_index_reg,
    // controls and pins
    input wire logic [2:0] uart2_mode,
    input wire logic uart2_half_duplex,
    input wire logic pll_stop,
    input wire logic ir_test_mode,
    input wire logic fdc_pd_timeout_test,
    input wire logic uart1_tx_data,
    input wire logic serial_out_pin,
    input wire logic host_select_n,
    input wire logic [10:0] host_addr,
    input wire logic joystick_chip_select_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence wr_at(logic [7:0] idx);
        cfg_mode && data_wr && config_index_reg == idx;
    endsequence
    chk_rd_answer: assert property (cfg_mode && data_rd |=> cfg_rvalid)
        else $error("accepted read not answered");
    chk_rd_refused: assert property (!(cfg_mode && data_rd) |=> !cfg_rvalid)
        else $error("answer without accepted read");
    chk_index_load: assert property (cfg_mode && index_wr |=> config_index_reg == $past(cfg_wdata))
        else $error("index not loaded");
    chk_index_hold: assert property (!cfg_mode |=> $stable(config_index_reg))
        else $error("index changed outside config mode");
    chk_mode_field: assert property (wr_at(`SCFG_IDX_SERIAL_MODE) |=> ##1
        {uart2_mode, uart2_half_duplex} == $past(cfg_wdata[5:2], 2))
        else $error("serial mode outputs wrong");
    chk_clock_bits: assert property (wr_at(`SCFG_IDX_CLOCK_CTRL) |=> ##1
        {ir_test_mode, pll_stop} == {$past(cfg_wdata[7], 2), $past(cfg_wdata[4], 2)})
        else $error("clock control outputs wrong");
    chk_pd_test: assert property (wr_at(`SCFG_IDX_IR_TEST) |=> ##1
        fdc_pd_timeout_test == $past(cfg_wdata[1], 2))
        else $error("timeout test output wrong");
    chk_serial_out_pin_normal: assert property (!ir_test_mode && !$past(ir_test_mode) |->
        serial_out_pin == $past(uart1_tx_data))
        else $error("serial out not following first channel");
    chk_game_qual: assert property (!joystick_chip_select_n |->
        !$past(host_select_n, 3) && !$past(host_addr[10], 3))
        else $error("game select without host select or with A10 high");
endmodule
bind scfg_regs scfg_regs_chk u_chk (.ref_clk, .rst, .cfg_mode, .index_wr, .data_wr, .data_rd, .cfg_wdata, .cfg_rvalid,
    .config_index_reg, .uart2_mode, .uart2_half_duplex, .pll_stop, .ir_test_mode, .fdc_pd_timeout_test,
    .uart1_tx_data, .serial_out_pin, .host_select_n, .host_addr, .joystick_chip_select_n);
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the configuration bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [7:0] ID = 8'hC3; // arbitrary value
    localparam logic [7:0] REV = 8'h3C; // arbitrary value
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_mode = 1'b0, index_wr = 1'b0, data_wr = 1'b0, data_rd = 1'b0;
    logic [7:0] cfg_wdata = 8'h00;
    logic [1:0] fdc_drive_sel = 2'h0;
    logic fdc_density_sel = 1'b0, rate_bit0 = 1'b0, rate_bit1 = 1'b0;
    logic uart1_tx_data = 1'b1, uart2_tx_data = 1'b1, uart2_tx_active = 1'b0, ir_receive_pin = 1'b1;
    logic game_pin_enable = 1'b0, host_select_n = 1'b1;
    logic [10:0] host_addr = 11'h000;
    logic [7:0] cfg_rdata, config_index_reg, ix;
    logic [1:0] rate_table_sel;
    logic [2:0] uart2_mode;
    logic cfg_rvalid, drive_density_out0, drive_density_out1, fdc_pd_timeout_test, uart2_rx_data;
    logic serial_out_pin, uart2_half_duplex, uart1_high_speed, uart_high_speed, ir_transmit_pin;
    logic pll_gain_double, pll_stop, serial_divider_halt, pll_input_24m, ir_test_mode, joystick_chip_select_n;
    logic [7:0] m [0:31];
    logic [7:0] tab [0:5] = '{8'h0B, 8'h0C, 8'h10, 8'h11, 8'h1E, 8'h1F};
    logic [31:0] seed = 32'hB60B;
    int n_fail = 0, n_compared = 0, cyc = 0;

    scfg_regs #(.DEVICE_ID(ID), .REVISION(REV)) u_scfg_regs (.ref_clk, .rst, .cfg_mode, .index_wr, .data_wr,
        .data_rd, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .config_index_reg, .fdc_drive_sel, .fdc_density_sel,
        .rate_bit0, .rate_bit1, .rate_table_sel, .drive_density_out0, .drive_density_out1, .fdc_pd_timeout_test,
        .uart1_tx_data, .uart2_tx_data, .uart2_tx_active, .uart2_rx_data, .serial_out_pin, .uart2_half_duplex,
        .uart2_mode, .uart1_high_speed, .uart_high_speed, .ir_receive_pin, .ir_transmit_pin, .pll_gain_double,
        .pll_stop, .serial_divider_halt, .pll_input_24m, .ir_test_mode, .game_pin_enable, .host_select_n,
        .host_addr, .joystick_chip_select_n);

    initial forever #2 ref_clk = ~ref_clk;

    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    function automatic logic isrw(input logic [7:0] i);
        return i inside {8'h0B, 8'h0C, 8'h0F, 8'h10, 8'h11, 8'h1E, 8'h1F};
    endfunction
    // reserved clock and infrared bits are never stored
    function automatic logic [7:0] msk(input logic [7:0] i);
        return i == 8'h10 ? 8'hF8 : i == 8'h11 ? 8'h03 : 8'hFF;
    endfunction
    function automatic logic [7:0] expv(input logic [7:0] i);
        if (i == 8'h0D) return ID;
        if (i == 8'h0E) return REV;
        return isrw(i) ? m[i[4:0]] : 8'h00;
    endfunction
    // expected active-low game select for the current pins
    function automatic logic gexp(input logic [7:0] b, input logic [10:0] a);
        logic lo;
        case (b[1:0])
            2'h0: lo = 1'b0;
            2'h1: lo = a[3:0] == 4'h1;
            2'h2: lo = !a[3];
            default: lo = 1'b1;
        endcase
        return !(lo && game_pin_enable && !host_select_n && !a[10] && a[9:4] == b[7:2]);
    endfunction

    task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic md = 1'b1);
        cfg_mode = md;
        index_wr = 1'b1;
        cfg_wdata = idx;
        step(1);
        index_wr = 1'b0;
        data_wr = 1'b1;
        cfg_wdata = d;
        step(1);
        data_wr = 1'b0;
        // mode left standing; the next call sets it once, at its start
        if (md && isrw(idx)) m[idx[4:0]] = d & msk(idx);
    endtask
    task automatic rd(input logic [7:0] idx, input logic md = 1'b1);
        cfg_mode = md;
        index_wr = 1'b1;
        cfg_wdata = idx;
        step(1);
        index_wr = 1'b0;
        data_rd = 1'b1;
        step(1);
        data_rd = 1'b0;
        cmp8("rvalid", 8'(md), cfg_rvalid);
        if (md) cmp8("rdata", expv(idx), cfg_rdata);
    endtask
    task automatic outs();
        logic [7:0] s, c, t;
        logic src;
        s = m[12];
        c = m[16];
        t = m[17];
        {uart2_tx_data, uart2_tx_active, ir_receive_pin, uart1_tx_data} = 4'(rnd());
        step(4);
        cmp8("mode", s[5:2], {uart2_mode, uart2_half_duplex});
        cmp8("speed", s[7:6], {uart_high_speed, uart1_high_speed});
        cmp8("clkhi", c[7:5], {ir_test_mode, pll_input_24m, serial_divider_halt});
        cmp8("clklo", c[4:3], {pll_stop, pll_gain_double});
        cmp8("pdt", t[1], fdc_pd_timeout_test);
        cmp8("irtx", uart2_tx_data ^ s[1], ir_transmit_pin);
        // loopback taps the already inverted transmit line
        src = t[0] ? uart2_tx_data ^ s[1] : ir_receive_pin;
        src = (s[2] && uart2_tx_active) ? 1'b1 : src ^ s[0];
        cmp8("rx", src, uart2_rx_data);
        cmp8("serial_out_pin", c[7] ? src & ir_transmit_pin : uart1_tx_data, serial_out_pin);
    endtask
    task automatic dens(input logic [1:0] k, input logic [1:0] tp);
        logic [7:0] v;
        logic [1:0] e;
        v = rnd();
        v[2*k +: 2] = tp;
        wr(8'h1F, v);
        wr(8'h0B, rnd());
        fdc_drive_sel = k;
        {fdc_density_sel, rate_bit1, rate_bit0} = 3'(rnd());
        step(3);
        case (tp)
            2'h0: e = {fdc_density_sel, rate_bit0};
            2'h1: e = {rate_bit1, rate_bit0};
            2'h2: e = {~fdc_density_sel, rate_bit0};
            default: e = {rate_bit0, rate_bit1};
        endcase
        cmp8("dens", e, {drive_density_out0, drive_density_out1});
        cmp8("rtsel", m[11][2*k +: 2], rate_table_sel);
    endtask
    task automatic game();
        logic [7:0] b;
        b = rnd();
        wr(8'h1E, b);
        game_pin_enable = rnd() > 8'h30;
        host_select_n = rnd() < 8'h30;
        host_addr = 11'({rnd(), rnd()});
        if (rnd() > 8'h40) host_addr[10:4] = {rnd() < 8'h30, b[7:2]};
        if (rnd() > 8'h80) host_addr[3:0] = 4'h1;
        step(4);
        cmp8("csn", gexp(b, host_addr), joystick_chip_select_n);
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // runaway guard, well above the roughly 930 cycles the run needs
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        for (int i = 0; i < 32; i++) m[i] = 8'h00;
        m[30] = 8'h80;
        step(16);
        rst = 1'b0;
        step(1);
        cmp8("index", 8'h00, config_index_reg);
        cmp8("csn", 8'h01, joystick_chip_select_n);
        for (int i = 11; i < 33; i++) rd(8'(i));
        wr(8'h0C, 8'h3F, 1'b0);
        rd(8'h0C);
        rd(8'h0C, 1'b0);
        wr(8'h0D, 8'hFF);
        wr(8'h0E, 8'h00);
        rd(8'h0D);
        rd(8'h0E);
        wr(8'h15, 8'hFF);
        rd(8'h15);
        wr(8'h0F, 8'h00);
        wr(8'h10, 8'hFF);
        wr(8'h11, 8'hFF);
        rd(8'h10);
        rd(8'h11);
        outs();
        for (int i = 0; i < 40; i++) begin
            ix = tab[rnd() % 6];
            wr(ix, rnd());
            rd(ix);
            outs();
        end
        // mid-run reset must return every written register to its reset value; serial line idle
        uart1_tx_data = 1'b1;
        rst = 1'b1;
        for (int i = 0; i < 32; i++) m[i] = 8'h00;
        m[30] = 8'h80;
        step(2);
        rst = 1'b0;
        step(1);
        for (int i = 11; i < 32; i++) rd(8'(i));
        for (int i = 0; i < 16; i++) dens(2'(i), 2'(i >> 2));
        for (int i = 0; i < 60; i++) game();
        test_done();
    end
endmodule
`default_nettype wire
